// ---- include/counter_array_pkg.sv ----
// Constants shared by the capture/compare counter array.
`default_nettype none
package counter_array_pkg;

  localparam int NUM_CH = 5;

  // Register addresses on the 8-bit special function register port.
  localparam logic [7:0] ADDR_CONTROL_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_COUNTER_LOW   = 8'h01;
  localparam logic [7:0] ADDR_COUNTER_HIGH  = 8'h02;
  localparam logic [7:0] ADDR_CHANNEL_BASE  = 8'h10;
  localparam logic [7:0] CHANNEL_STRIDE     = 8'h04;
  localparam logic [7:0] OFS_MODE_SELECT    = 8'h00;
  localparam logic [7:0] OFS_COMPARE_LOW    = 8'h01;
  localparam logic [7:0] OFS_COMPARE_HIGH   = 8'h02;

  // Field positions in channel_mode_select.
  localparam int BIT_IRQ_ENABLE      = 0;
  localparam int BIT_PWM_SELECT      = 1;
  localparam int BIT_TOGGLE          = 2;
  localparam int BIT_MATCH_ENABLE    = 3;
  localparam int BIT_CAPTURE_FALLING = 4;
  localparam int BIT_CAPTURE_RISING  = 5;
  localparam int BIT_COMPARATOR_ON   = 6;
  localparam int BIT_WIDE_PWM        = 7;

  // Field positions in array_control_flags.
  localparam int BIT_OVERFLOW_FLAG = 7;

  // Values after reset.
  localparam logic [7:0]  MODE_RESET    = 8'h00;
  localparam logic [7:0]  COMPARE_RESET = 8'h00;
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [7:0]  READ_UNMAPPED = 8'h00;

endpackage
`default_nettype wire

// ---- logic/pin_edge_sync.sv ----
// Two-stage pin synchroniser with rising and falling edge detection.
`default_nettype none
module pin_edge_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin_async,
  output logic      rise,
  output logic      fall
);

  logic stage1;
  logic stage2;
  logic last;

  // Only stage2 reads stage1; edges compare stage2 with its older copy.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      last   <= 1'b0;
    end else begin
      stage1 <= pin_async;
      stage2 <= stage1;
      last   <= stage2;
    end
  end

  // A level shorter than one clock may vanish here unseen.
  assign rise = stage2 & ~last;
  assign fall = ~stage2 & last;

endmodule
`default_nettype wire

// ---- logic/counter_array.sv ----
// Shared 16-bit timebase counter with five capture/compare channels.
`default_nettype none
// Summary of operation
// - Mode bits 3..1 zero give capture; bit 5 rising, bit 4 falling.
// - Bits 6 and 3 give timer; adding 2 toggles; 6, 2, 1 square wave.
// - Bit 1 with bits 5..2 clear (3 free) is PWM; bit 7 picks 16-bit.
// - Channel interrupt asserts while its flag and mode bit 0 are set.
// - Comparator off: toggle/square pin holds, PWM pin held low.
// - Capture edge copies the counter into compare and sets the flag.
// - Hardware never clears a channel flag; only software writes it zero.
// - Timer mode sets the flag when counter equals the compare word.
// - Compare low write clears comparator enable; high write sets it.
// - Toggle mode inverts pin and flags on each 16-bit match.
// - Square wave: low-byte match toggles pin, adds high to low byte.
// - Square wave high byte zero means a half period of 256 ticks.
// - Square wave with match enable flags on full 16-bit equality.
// - 8-bit PWM: pin high on low-byte match, low on low-byte rollover.
// - 8-bit PWM reloads compare low from compare high at rollover.
// - 8-bit PWM with match enable flags on every 8-bit match.
// - 16-bit PWM: high on 16-bit match, low on overflow, optional flag.
// - PWM duty is (256-high)/256 or (65536-word)/65536; zero is 100%.
// - Counter is 16 bits; rollover from all ones sets overflow flag.
// - Five independent channels, each with compare word and own pin.
module counter_array
  import counter_array_pkg::*;
(
  input  wire logic              MCLK,
  input  wire logic              RST_N,
  input  wire logic              COUNT_TICK,
  input  wire logic [7:0]        SFR_ADDR,
  input  wire logic              SFR_WR,
  input  wire logic [7:0]        SFR_WDATA,
  input  wire logic              SFR_RD,
  output logic      [7:0]        SFR_RDATA,
  input  wire logic [NUM_CH-1:0] CHANNEL_PIN_IN,
  output logic      [NUM_CH-1:0] CHANNEL_PIN_OUT,
  output logic      [NUM_CH-1:0] CHANNEL_PIN_OE,
  output logic      [NUM_CH-1:0] CHANNEL_IRQ
);

  // Address of one register of a channel.
  function automatic logic [7:0] chan_addr(input int ch,
                                           input logic [7:0] ofs);
    logic [7:0] idx;
    idx = 8'(ch);
    chan_addr = 8'(ADDR_CHANNEL_BASE + idx * CHANNEL_STRIDE + ofs);
  endfunction

  // Channel operating modes, decided from the mode select byte.
  typedef enum logic [2:0] {
    KIND_CAPTURE,
    KIND_TIMER,
    KIND_TOGGLE,
    KIND_SQUARE,
    KIND_PWM,
    KIND_NONE
  } mode_kind_t;

  // Patterns that name no mode fall to KIND_NONE, where the pin just holds.
  // One decode for all five channels keeps them from drifting apart.
  function automatic mode_kind_t decode_mode(input logic [7:0] m);
    logic no_capt;
    logic tog;
    logic pwm;
    no_capt = ~m[BIT_CAPTURE_RISING] & ~m[BIT_CAPTURE_FALLING];
    tog     = m[BIT_TOGGLE];
    pwm     = m[BIT_PWM_SELECT];
    if (m[3:1] == 3'b000) begin
      decode_mode = KIND_CAPTURE;
    end else if (no_capt & m[BIT_MATCH_ENABLE] & ~tog & ~pwm) begin
      decode_mode = KIND_TIMER;
    end else if (no_capt & m[BIT_MATCH_ENABLE] & tog & ~pwm) begin
      decode_mode = KIND_TOGGLE;
    end else if (no_capt & tog & pwm) begin
      decode_mode = KIND_SQUARE;
    end else if (no_capt & ~tog & pwm) begin
      decode_mode = KIND_PWM;
    end else begin
      decode_mode = KIND_NONE;
    end
  endfunction

  logic [15:0]       count;
  logic [7:0]        count_snapshot;
  logic              overflow_flag;
  logic [NUM_CH-1:0] event_flag;
  logic [7:0]        mode_select   [NUM_CH];
  logic [7:0]        compare_low   [NUM_CH];
  logic [7:0]        compare_high  [NUM_CH];
  logic [NUM_CH-1:0] pin_level;
  logic [NUM_CH-1:0] flag_set;
  logic [NUM_CH-1:0] pin_rise;
  logic [NUM_CH-1:0] pin_fall;
  logic [NUM_CH-1:0] output_mode;

  // Counter and shared decode.
  wire        wr_control   = SFR_WR && (SFR_ADDR == ADDR_CONTROL_FLAGS);
  wire        wr_cnt_low   = SFR_WR && (SFR_ADDR == ADDR_COUNTER_LOW);
  wire        wr_cnt_high  = SFR_WR && (SFR_ADDR == ADDR_COUNTER_HIGH);
  wire        rd_cnt_low   = SFR_RD && (SFR_ADDR == ADDR_COUNTER_LOW);
  wire [15:0] next_count   = 16'(count + 16'h0001);
  // Match and rollover events are judged on the value the tick produces.
  wire        counter_wrap = COUNT_TICK && (next_count == 16'h0000);
  wire        low_wrap     = COUNT_TICK && (next_count[7:0] == 8'h00);

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      count <= COUNTER_RESET;
    end else if (wr_cnt_low) begin
      count <= {count[15:8], SFR_WDATA};
    end else if (wr_cnt_high) begin
      count <= {SFR_WDATA, count[7:0]};
    end else if (COUNT_TICK) begin
      count <= next_count;
    end
  end

  // Reading the low byte freezes the high byte so a byte pair reads whole.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      count_snapshot <= COUNTER_RESET[15:8];
    end else if (rd_cnt_low) begin
      count_snapshot <= count[15:8];
    end
  end

  wire next_overflow = counter_wrap |
                       (wr_control ? SFR_WDATA[BIT_OVERFLOW_FLAG]
                                   : overflow_flag);

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      overflow_flag <= 1'b0;
    end else begin
      overflow_flag <= next_overflow;
    end
  end

  // Per-channel logic.
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
      wire [7:0]  m        = mode_select[ch];
      wire [15:0] cmp_word = {compare_high[ch], compare_low[ch]};
      wire        ecom     = m[BIT_COMPARATOR_ON];
      wire        mat      = m[BIT_MATCH_ENABLE];

      wire wr_mode = SFR_WR && (SFR_ADDR == chan_addr(ch, OFS_MODE_SELECT));
      wire wr_low  = SFR_WR && (SFR_ADDR == chan_addr(ch, OFS_COMPARE_LOW));
      wire wr_high = SFR_WR && (SFR_ADDR == chan_addr(ch, OFS_COMPARE_HIGH));

      // Mode decode.
      mode_kind_t kind;
      assign kind = decode_mode(m);
      wire capture_mode = (kind == KIND_CAPTURE);
      wire timer_mode   = (kind == KIND_TIMER);
      wire toggle_mode  = (kind == KIND_TOGGLE);
      wire square_mode  = (kind == KIND_SQUARE);
      wire pwm_mode     = (kind == KIND_PWM);
      wire wide_pwm     = m[BIT_WIDE_PWM];

      // Comparators.
      wire match16 = COUNT_TICK && (next_count == cmp_word);
      wire match8  = COUNT_TICK && (next_count[7:0] == compare_low[ch]);
      // At rollover the reloaded value is the one that counts, so a high
      // byte of zero sets the pin in the same tick that clears it.
      wire [7:0] pwm8_cmp   = low_wrap ? compare_high[ch] : compare_low[ch];
      wire       pwm8_match = COUNT_TICK &&
                              (next_count[7:0] == pwm8_cmp);

      // Capture.
      wire capture_hit = capture_mode &
                         ((m[BIT_CAPTURE_RISING] & pin_rise[ch]) |
                          (m[BIT_CAPTURE_FALLING] & pin_fall[ch]));

      // Event flag sources.
      wire timer_hit  = ecom & (timer_mode | toggle_mode) &
                        match16;
      wire square_hit = ecom & square_mode & mat & match16;
      wire pwm_hit    = ecom & pwm_mode & mat &
                        (wide_pwm ? match16 : pwm8_match);

      assign flag_set[ch] = capture_hit | timer_hit |
                            square_hit | pwm_hit;

      // Pin drive.
      wire pwm_next   = ~ecom            ? 1'b0 :
                        wide_pwm         ?
                          (match16       ? 1'b1 :
                           counter_wrap  ? 1'b0 : pin_level[ch]) :
                          (pwm8_match    ? 1'b1 :
                           low_wrap      ? 1'b0 : pin_level[ch]);
      wire toggle_now = ecom & ((toggle_mode & match16) |
                                (square_mode & match8));
      wire next_pin   = pwm_mode   ? pwm_next :
                        toggle_now ? ~pin_level[ch] :
                        pin_level[ch];

      // Compare register update. Software writes take precedence.
      // The square wave step wraps inside the byte on purpose, so a high
      // byte of zero leaves the low byte alone and the next match comes
      // a full 256 ticks later.
      wire [7:0] square_step = 8'(compare_low[ch] + compare_high[ch]);
      wire [7:0] next_low    =
        wr_low                                     ? SFR_WDATA :
        capture_hit                                ? count[7:0] :
        (pwm_mode & ~wide_pwm & low_wrap)          ? compare_high[ch] :
        (square_mode & ecom & match8)              ? square_step :
        compare_low[ch];
      wire [7:0] next_high   = wr_high     ? SFR_WDATA :
                               capture_hit ? count[15:8] :
                               compare_high[ch];

      wire [7:0] next_mode =
        wr_mode ? SFR_WDATA :
        wr_low  ? (m & ~(8'h01 << BIT_COMPARATOR_ON)) :
        wr_high ? (m | (8'h01 << BIT_COMPARATOR_ON)) :
        m;

      // Hardware only ever sets the flag; a same-cycle set beats the clear.
      wire next_flag = flag_set[ch] |
                       (wr_control ? SFR_WDATA[ch]
                                   : event_flag[ch]);

      always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
          mode_select[ch]  <= MODE_RESET;
          compare_low[ch]  <= COMPARE_RESET;
          compare_high[ch] <= COMPARE_RESET;
          pin_level[ch]    <= 1'b0;
          event_flag[ch]   <= 1'b0;
        end else begin
          mode_select[ch]  <= next_mode;
          compare_low[ch]  <= next_low;
          compare_high[ch] <= next_high;
          pin_level[ch]    <= next_pin;
          event_flag[ch]   <= next_flag;
        end
      end

      assign output_mode[ch] = ~capture_mode;

      pin_edge_sync u_sync (
        .clk       (MCLK),
        .rst_n     (RST_N),
        .pin_async (CHANNEL_PIN_IN[ch]),
        .rise      (pin_rise[ch]),
        .fall      (pin_fall[ch])
      );

      assign CHANNEL_IRQ[ch] = event_flag[ch] &
                               m[BIT_IRQ_ENABLE];
    end
  endgenerate

  // The pin is only driven outside capture mode; capture listens instead.
  // A mode change therefore turns the pin around within the same cycle,
  // so the board must tolerate a short undriven spell on the pin.
  assign CHANNEL_PIN_OUT = pin_level;
  assign CHANNEL_PIN_OE  = output_mode;

  // Read path.
  // The data is registered only when a read strobe is seen, so software
  // sees a stable byte even while the counter keeps running underneath.
  logic [7:0] read_value;

  always_comb begin
    read_value = READ_UNMAPPED;
    if (SFR_ADDR == ADDR_CONTROL_FLAGS) begin
      read_value = 8'h00;
      read_value[BIT_OVERFLOW_FLAG] = overflow_flag;
      read_value[NUM_CH-1:0] = event_flag;
    end else if (SFR_ADDR == ADDR_COUNTER_LOW) begin
      read_value = count[7:0];
    end else if (SFR_ADDR == ADDR_COUNTER_HIGH) begin
      read_value = count_snapshot;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (SFR_ADDR == chan_addr(i, OFS_MODE_SELECT)) begin
        read_value = mode_select[i];
      end
      if (SFR_ADDR == chan_addr(i, OFS_COMPARE_LOW)) begin
        read_value = compare_low[i];
      end
      if (SFR_ADDR == chan_addr(i, OFS_COMPARE_HIGH)) begin
        read_value = compare_high[i];
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      SFR_RDATA <= READ_UNMAPPED;
    end else if (SFR_RD) begin
      SFR_RDATA <= read_value;
    end
  end

endmodule
`default_nettype wire

// ---- tb/counter_array_props.sv ----
// Port-level concurrent checks for the counter array.
`default_nettype none
module counter_array_props
  import counter_array_pkg::*;
(
  input wire logic              MCLK,
  input wire logic              RST_N,
  input wire logic              COUNT_TICK,
  input wire logic [7:0]        SFR_ADDR,
  input wire logic              SFR_WR,
  input wire logic [7:0]        SFR_WDATA,
  input wire logic              SFR_RD,
  input wire logic [7:0]        SFR_RDATA,
  input wire logic [NUM_CH-1:0] CHANNEL_PIN_OUT,
  input wire logic [NUM_CH-1:0] CHANNEL_PIN_OE,
  input wire logic [NUM_CH-1:0] CHANNEL_IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mode0;
  logic       pwm_off;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // Software view of channel 0 mode, so checks know what it was told.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) mode0 <= 8'h00;
    else if (SFR_WR && SFR_ADDR == 8'h10) mode0 <= SFR_WDATA;
    else if (SFR_WR && SFR_ADDR == 8'h11) mode0[6] <= 1'b0;
    else if (SFR_WR && SFR_ADDR == 8'h12) mode0[6] <= 1'b1;
  end
  assign pwm_off = mode0[1] && !mode0[2] && !mode0[6] &&
                   !mode0[5] && !mode0[4];
  capture_no_drive_a: assert property (
    CHANNEL_PIN_OE[0] == (mode0[3:1] != 3'b000))
    else $error("pin drive disagrees with mode");
  irq_enable_a: assert property (
    CHANNEL_IRQ[0] |-> mode0[0])
    else $error("interrupt without enable");
  irq_sticky_a: assert property (
    $fell(CHANNEL_IRQ[0]) |-> $past(SFR_WR))
    else $error("interrupt dropped without a write");
  match_on_tick_a: assert property (
    $rose(CHANNEL_IRQ[0]) && mode0[3:1] != 3'b000
    |-> $past(COUNT_TICK) || $past(SFR_WR))
    else $error("compare event without a tick");
  pwm_off_low_a: assert property (
    pwm_off [*3] |-> !CHANNEL_PIN_OUT[0])
    else $error("pwm pin high with comparator off");
  pin_hold_a: assert property (
    !COUNT_TICK && !SFR_WR ##1 !COUNT_TICK && !SFR_WR
    |=> $stable(CHANNEL_PIN_OUT))
    else $error("pin moved while idle");
  pin_rise_tick_a: assert property (
    $rose(CHANNEL_PIN_OUT[0]) |-> $past(COUNT_TICK))
    else $error("pin rose without a tick");
  unmapped_read_a: assert property (
    SFR_RD && SFR_ADDR == 8'h03 |=> SFR_RDATA == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind counter_array counter_array_props counter_array_props_inst (.*);
`default_nettype wire

// ---- tb/pin_partner.sv ----
// External pin source and wire resolution for the channel pins.
`default_nettype none
module pin_partner (
  input  wire logic       clk,
  input  wire logic [4:0] level,
  input  wire logic [4:0] oe,
  input  wire logic [4:0] out,
  output logic      [4:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] held;
  // Levels move only on clock edges, so each lasts whole cycles.
  always_ff @(posedge clk) held <= level;
  assign pin = (oe & out) | (~oe & held);
endmodule
`default_nettype wire

// ---- tb/counter_array_bench.sv ----
// Self-checking bench for the counter array.
`default_nettype none
module counter_array_bench;
  import counter_array_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              tk = 1'b0;
  logic [7:0]        addr = 8'h00;
  logic [7:0]        wdata = 8'h00;
  logic              we = 1'b0;
  logic              re = 1'b0;
  logic [NUM_CH-1:0] lvl = 5'h00;
  logic [7:0]        rdata;
  logic [NUM_CH-1:0] pin_in, pin_out, oe, irq;
  int                errors = 0;
  int                checks = 0;
  // Write address and data, then read address and expected value.
  logic [31:0]       rows [8] = '{
    32'h03ff_1400, 32'h104b_104b, 32'h1134_100b, 32'h1256_104b,
    32'h1256_1256, 32'h03ff_0300, 32'h00ff_009f, 32'h0000_0000};
  always #25 clk = ~clk;
  counter_array counter_array_inst (
    .MCLK(clk), .RST_N(rst_n), .COUNT_TICK(tk), .SFR_ADDR(addr),
    .SFR_WR(we), .SFR_WDATA(wdata), .SFR_RD(re), .SFR_RDATA(rdata),
    .CHANNEL_PIN_IN(pin_in), .CHANNEL_PIN_OUT(pin_out),
    .CHANNEL_PIN_OE(oe), .CHANNEL_IRQ(irq));
  pin_partner pin_partner_inst (
    .clk(clk), .level(lvl), .oe(oe), .out(pin_out), .pin(pin_in));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    addr = a;
    wdata = d;
    we = 1'b1;
    @(posedge clk) #1;
    we = 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) #1;
    addr = a;
    re = 1'b1;
    @(posedge clk) #1;
    re = 1'b0;
    chk(rdata, e);
  endtask
  task automatic tick(input int n);
    @(posedge clk) #1;
    tk = 1'b1;
    repeat (n) @(posedge clk);
    #1;
    tk = 1'b0;
  endtask
  task automatic final_report;
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1;
    chk(rdata, 8'h00);
    chk({3'b000, oe}, 8'h00);
    chk({3'b000, irq}, 8'h00);
    @(posedge clk) #1;
    rst_n = 1'b1;
    foreach (rows[i]) begin
      wr(rows[i][31:24], rows[i][23:16]);
      rdchk(rows[i][15:8], rows[i][7:0]);
    end
    // Wide pwm on channel 0 across a counter overflow.
    wr(8'h01, 8'hfe);
    wr(8'h02, 8'hff);
    wr(8'h10, 8'h8b);
    wr(8'h11, 8'h02);
    wr(8'h12, 8'h00);
    tick(3);
    chk({7'h00, pin_out[0]}, 8'h00);
    tick(1);
    chk({7'h00, pin_out[0]}, 8'h01);
    chk({7'h00, irq[0]}, 8'h01);
    rdchk(8'h00, 8'h81);
    rdchk(8'h01, 8'h02);
    rdchk(8'h02, 8'h00);
    wr(8'h01, 8'hff);
    wr(8'h02, 8'hff);
    tick(1);
    chk({7'h00, pin_out[0]}, 8'h00);
    wr(8'h01, 8'h01);
    wr(8'h02, 8'h00);
    wr(8'h10, 8'h8b);
    tick(1);
    chk({7'h00, pin_out[0]}, 8'h00);
    rdchk(8'h00, 8'h81);
    wr(8'h00, 8'h00);
    chk({7'h00, irq[0]}, 8'h00);
    // Narrow pwm on channel 2 with reload at low byte rollover.
    wr(8'h18, 8'h0a);
    wr(8'h19, 8'h10);
    wr(8'h1a, 8'h80);
    wr(8'h01, 8'hfe);
    wr(8'h02, 8'h00);
    tick(2);
    rdchk(8'h19, 8'h80);
    tick(127);
    chk({7'h00, pin_out[2]}, 8'h00);
    tick(1);
    chk({7'h00, pin_out[2]}, 8'h01);
    rdchk(8'h00, 8'h04);
    chk({7'h00, irq[2]}, 8'h00);
    // Toggle output on channel 1, then with the comparator off.
    wr(8'h14, 8'h0d);
    wr(8'h15, 8'h05);
    wr(8'h16, 8'h00);
    wr(8'h01, 8'h04);
    wr(8'h02, 8'h00);
    tick(1);
    chk({7'h00, pin_out[1]}, 8'h01);
    chk({7'h00, irq[1]}, 8'h01);
    wr(8'h15, 8'h05);
    wr(8'h01, 8'h04);
    tick(1);
    chk({7'h00, pin_out[1]}, 8'h01);
    // Rising capture on channel 4; a falling edge must be ignored.
    wr(8'h00, 8'h00);
    wr(8'h20, 8'h21);
    wr(8'h01, 8'h34);
    wr(8'h02, 8'h12);
    lvl[4] = 1'b1;
    repeat (6) @(posedge clk);
    rdchk(8'h21, 8'h34);
    rdchk(8'h22, 8'h12);
    chk({7'h00, irq[4]}, 8'h01);
    wr(8'h00, 8'h00);
    lvl[4] = 1'b0;
    repeat (6) @(posedge clk);
    rdchk(8'h00, 8'h00);
    // Square wave on channel 3: a step of three, then a zero step.
    wr(8'h1c, 8'h0e);
    wr(8'h1d, 8'h10);
    wr(8'h1e, 8'h03);
    wr(8'h01, 8'h0e);
    wr(8'h02, 8'h00);
    tick(2);
    chk({7'h00, pin_out[3]}, 8'h01);
    rdchk(8'h1d, 8'h13);
    tick(3);
    chk({7'h00, pin_out[3]}, 8'h00);
    wr(8'h02, 8'h03);
    tick(3);
    rdchk(8'h00, 8'h08);
    wr(8'h1e, 8'h00);
    tick(3);
    tick(255);
    chk({7'h00, pin_out[3]}, 8'h00);
    tick(1);
    chk({7'h00, pin_out[3]}, 8'h01);
    final_report();
  end
endmodule
`default_nettype wire
